// ==== inc/pwm_core_map.svh ====
// timing, level and count constants for the flyback pwm core
`ifndef PWM_CORE_MAP_SVH
`define PWM_CORE_MAP_SVH
`define CLK_HZ 10000000
`define NOM_FREQ_HZ 65000
`define GREEN_FREQ_HZ 22500
`define HOP_LO_FREQ_HZ 60800
`define HOP_HI_FREQ_HZ 69200
`define HOP_PERIOD_US 4400
`define LEB_NS 360
`define SS_TIME_MS 4
`define OLP_DLY_MS 56
`define OCP_DLY_MS 56
`define OVP_DLY_US 30
`define OTP1_DLY_MS 17
`define OTP2_DLY_US 100
`define SCP_DLY_CYC 1
`define US_CYC(t) ((t) * (`CLK_HZ / 1000000))
`define MS_CYC(t) ((t) * (`CLK_HZ / 1000))
`define PER_NOM_CYC (`CLK_HZ / `NOM_FREQ_HZ)
`define PER_GREEN_CYC (`CLK_HZ / `GREEN_FREQ_HZ)
`define PER_HOP_MIN_CYC (`CLK_HZ / `HOP_HI_FREQ_HZ)
`define PER_HOP_MAX_CYC (`CLK_HZ / `HOP_LO_FREQ_HZ)
`define HOP_STEPS (`PER_HOP_MAX_CYC - `PER_HOP_MIN_CYC)
`define LEB_CYC ((`LEB_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define DUTY_MAX_PCT 70
`define FB_N_MV 2200
`define FB_G_MV 2100
`define ILIM_VALLEY_MV 440
`define ILIM_FLAT_MV 500
`endif

// ==== inc/pwm_core_pkg.sv ====
// types shared by the flyback pwm core
package pwm_core_pkg;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_AUTO = 2'b10,
		ST_LATCH = 2'b11
	} run_state_t;
	typedef enum logic [1:0] {
		MODE_NOM = 2'b00,
		MODE_REDUCE = 2'b01,
		MODE_GREEN = 2'b10,
		MODE_BURST = 2'b11
	} load_mode_t;
endpackage : pwm_core_pkg

// ==== hw/fault_debounce.sv ====
// consecutive-cycle debounce timer for one fault condition
`timescale 1ns/1ns
`default_nettype none
module fault_debounce #(
	parameter int CNT_W = 20,
	parameter int LIMIT = 300
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_cond,
	output logic o_hit
);
	localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
	logic [CNT_W-1:0] cnt_q;

	// restart whenever the condition drops before expiry
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			if (!i_cond) begin
				cnt_q <= '0;
			end else if (cnt_q != LIM) begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	assign o_hit = (cnt_q == LIM);

	AST_DEB_RESTART: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && !i_cond |=> !o_hit)
		else $error("debounce did not restart on condition loss");
endmodule : fault_debounce
`default_nettype wire

// ==== hw/green_mode_flyback_pwm_core.sv ====
// digital control core of a green-mode current-mode flyback pwm controller
`timescale 1ns/1ns
`default_nettype none
`include "pwm_core_map.svh"
// Overview of operation
// - gate off until supply reaches turn-on level
// - heavy load runs at nominal switching rate
// - period rises linearly as feedback falls below threshold
// - below green floor, minimum frequency fixed
// - burst mode stops switching below zero-duty
// - hopping sweeps nominal frequency, fixed sweep period
// - overload, overcurrent, short restart; overvoltage, second-level overtemp latch
// - auto-restart fault clears at off level
// - latching fault clears only below four volts
// - current trip ends gate for the cycle
// - sustained overcurrent raises auto-restart fault
// - sustained high feedback raises open-loop fault
// - debounced supply overvoltage raises latching fault
// - first overtemp level disables gate after debounce
// - second overtemp level latches after shorter debounce
// - current limit reference is per-cycle sawtooth
// - current comparator blanked after each turn-on
// - soft-start ramps current limit reference
module green_mode_flyback_pwm_core
	import pwm_core_pkg::*;
#(
	parameter int PER_W = 10,
	parameter int REF_W = 10,
	parameter int FB_W = 12,
	parameter int DEB_W = 20,
	parameter int OLP_CYC = `MS_CYC(`OLP_DLY_MS),
	parameter int OCP_CYC = `MS_CYC(`OCP_DLY_MS),
	parameter int OTP1_CYC = `MS_CYC(`OTP1_DLY_MS),
	parameter int SS_CYC = `MS_CYC(`SS_TIME_MS),
	parameter int HOP_CYC = `US_CYC(`HOP_PERIOD_US)
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_vdd_on,
	input wire logic i_vdd_above_off,
	input wire logic i_vdd_above_4v,
	input wire logic i_vdd_ovp,
	input wire logic i_fb_above_olp,
	input wire logic i_fb_above_n,
	input wire logic i_fb_above_g,
	input wire logic i_fb_above_zdc,
	input wire logic [FB_W-1:0] i_fb_mv,
	input wire logic i_cs_trip,
	input wire logic i_cs_ocp,
	input wire logic i_cs_short,
	input wire logic i_rt_below_1v0,
	input wire logic i_rt_below_0v7,
	output logic o_gate,
	output logic [REF_W-1:0] o_ilim_ref,
	output logic [1:0] o_mode,
	output logic o_switching,
	output logic o_auto_fault,
	output logic o_latch_fault,
	output logic o_otp_hold
);
	localparam int NSYNC = 12;
	localparam int HOP_W = 6;
	localparam int DIV_W = 16;
	localparam int SAW_W = REF_W + 2;
	localparam int TURN_ON_BLANKING = `LEB_CYC;
	localparam int P_NOM = `PER_NOM_CYC;
	localparam int P_GRN = `PER_GREEN_CYC;
	localparam int P_HMIN = `PER_HOP_MIN_CYC;
	localparam int P_HMAX = `PER_HOP_MAX_CYC;
	localparam int HOP_N = `HOP_STEPS;
	localparam int HOP_S = HOP_CYC / (2 * HOP_N);
	localparam int HOP_STEP = (HOP_S < 1) ? 1 : HOP_S;
	localparam int SS_S = SS_CYC / `ILIM_FLAT_MV;
	localparam int SS_STEP = (SS_S < 1) ? 1 : SS_S;
	localparam logic [REF_W-1:0] VALLEY = REF_W'(`ILIM_VALLEY_MV);
	localparam logic [REF_W-1:0] FLAT = REF_W'(`ILIM_FLAT_MV);

	////////////////////////////////////////////////////////////////////
	// input synchroniser
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [FB_W-1:0] fb_q;
	logic vdd_on;
	logic vdd_above_off;
	logic vdd_above_4v;
	logic vdd_ovp;
	logic fb_above_olp;
	logic fb_above_n;
	logic fb_above_g;
	logic fb_above_zdc;
	logic cs_trip;
	logic cs_ocp;
	logic cs_short;
	logic rt_below_1v0;
	logic rt_below_0v7;

	assign raw = {i_vdd_on, i_vdd_above_off, i_vdd_above_4v, i_vdd_ovp,
		i_fb_above_olp, i_fb_above_n, i_fb_above_g, i_fb_above_zdc,
		i_cs_trip, i_cs_ocp, i_cs_short, i_rt_below_1v0};

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (i_ce) begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	// second temperature level skips the shared pair and goes through its own two stages
	logic otp2_s1_q;
	logic otp2_s2_q;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			otp2_s1_q <= 1'b0;
			otp2_s2_q <= 1'b0;
			fb_q <= '0;
		end else if (i_ce) begin
			otp2_s1_q <= i_rt_below_0v7;
			otp2_s2_q <= otp2_s1_q;
			fb_q <= i_fb_mv;
		end
	end

	assign {vdd_on, vdd_above_off, vdd_above_4v, vdd_ovp,
		fb_above_olp, fb_above_n, fb_above_g, fb_above_zdc,
		cs_trip, cs_ocp, cs_short, rt_below_1v0} = s2_q;
	assign rt_below_0v7 = otp2_s2_q;

	////////////////////////////////////////////////////////////////////
	// protection timers
	run_state_t st_q;
	logic running;
	logic olp_hit;
	logic ocp_hit;
	logic scp_hit;
	logic ovp_hit;
	logic otp1_hit;
	logic otp2_hit;
	logic auto_trig;
	logic latch_trig;

	assign running = (st_q == ST_RUN);

	fault_debounce #(.CNT_W(DEB_W), .LIMIT(OLP_CYC)) u_olp (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(fb_above_olp && running),
		.o_hit(olp_hit)
	);
	fault_debounce #(.CNT_W(DEB_W), .LIMIT(OCP_CYC)) u_ocp (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(cs_ocp && running),
		.o_hit(ocp_hit)
	);
	fault_debounce #(.CNT_W(DEB_W), .LIMIT(`SCP_DLY_CYC)) u_scp (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(cs_short && running),
		.o_hit(scp_hit)
	);
	fault_debounce #(.CNT_W(DEB_W), .LIMIT(`US_CYC(`OVP_DLY_US))) u_ovp (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(vdd_ovp),
		.o_hit(ovp_hit)
	);
	fault_debounce #(.CNT_W(DEB_W), .LIMIT(OTP1_CYC)) u_otp1 (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(rt_below_1v0),
		.o_hit(otp1_hit)
	);
	fault_debounce #(.CNT_W(DEB_W), .LIMIT(`US_CYC(`OTP2_DLY_US))) u_otp2 (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
		.i_cond(rt_below_0v7),
		.o_hit(otp2_hit)
	);

	assign auto_trig = olp_hit || ocp_hit || scp_hit;
	assign latch_trig = ovp_hit || otp2_hit;

	////////////////////////////////////////////////////////////////////
	// run and fault state
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_q <= ST_OFF;
		end else if (i_ce) begin
			case (st_q)
				ST_OFF: begin
					if (latch_trig) begin
						st_q <= ST_LATCH;
					end else if (vdd_on && vdd_above_off) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (latch_trig) begin
						st_q <= ST_LATCH;
					end else if (auto_trig) begin
						st_q <= ST_AUTO;
					end else if (!vdd_above_off) begin
						st_q <= ST_OFF;
					end
				end
				ST_AUTO: begin
					if (latch_trig) begin
						st_q <= ST_LATCH;
					end else if (!vdd_above_off) begin
						st_q <= ST_OFF;
					end
				end
				ST_LATCH: begin
					if (!vdd_above_4v) begin
						st_q <= ST_OFF;
					end
				end
				default: begin
					st_q <= ST_OFF;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// load mode and period selection
	load_mode_t mode_q;
	load_mode_t mode_d;
	logic [HOP_W-1:0] hop_q;
	logic hop_up_q;
	logic [DIV_W-1:0] hop_div_q;
	logic [PER_W-1:0] cnt_q;
	logic [PER_W-1:0] per_q;
	logic [PER_W-1:0] max_on;
	logic cyc_end;

	always_comb begin
		if (!fb_above_zdc) begin
			mode_d = MODE_BURST;
		end else if (!fb_above_g) begin
			mode_d = MODE_GREEN;
		end else if (!fb_above_n) begin
			mode_d = MODE_REDUCE;
		end else begin
			mode_d = MODE_NOM;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mode_q <= MODE_NOM;
		end else if (i_ce) begin
			mode_q <= mode_d;
		end
	end

	function automatic logic [PER_W-1:0] calc_period(
		input load_mode_t m,
		input logic [HOP_W-1:0] hop,
		input logic [FB_W-1:0] fb
	);
		int f;
		int p;
		f = int'(fb);
		if (f > `FB_N_MV) begin
			f = `FB_N_MV;
		end
		if (f < `FB_G_MV) begin
			f = `FB_G_MV;
		end
		case (m)
			MODE_NOM: p = P_HMIN + int'(hop);
			MODE_REDUCE: p = P_NOM + ((`FB_N_MV - f) * (P_GRN - P_NOM))
				/ (`FB_N_MV - `FB_G_MV);
			default: p = P_GRN;
		endcase
		return PER_W'(p);
	endfunction : calc_period

	// triangular sweep of the nominal period
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			hop_q <= '0;
			hop_up_q <= 1'b1;
			hop_div_q <= '0;
		end else if (i_ce) begin
			if (hop_div_q == DIV_W'(HOP_STEP - 1)) begin
				hop_div_q <= '0;
				if (hop_up_q) begin
					hop_q <= hop_q + HOP_W'(1);
					if (hop_q == HOP_W'(HOP_N - 1)) begin
						hop_up_q <= 1'b0;
					end
				end else begin
					hop_q <= hop_q - HOP_W'(1);
					if (hop_q == HOP_W'(1)) begin
						hop_up_q <= 1'b1;
					end
				end
			end else begin
				hop_div_q <= hop_div_q + DIV_W'(1);
			end
		end
	end

	assign cyc_end = (cnt_q == per_q - PER_W'(1));
	assign max_on = PER_W'((int'(per_q) * `DUTY_MAX_PCT) / 100);

	// switching period counter, period taken at each cycle boundary
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= '0;
			per_q <= PER_W'(P_NOM);
		end else if (i_ce) begin
			if (!running) begin
				cnt_q <= '0;
				per_q <= PER_W'(P_NOM);
			end else if (cyc_end) begin
				cnt_q <= '0;
				per_q <= calc_period(mode_q, hop_q, fb_q);
			end else begin
				cnt_q <= cnt_q + PER_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// soft-start and sawtooth current limit reference
	logic [REF_W-1:0] ss_q;
	logic [DIV_W-1:0] ss_div_q;
	logic [REF_W-1:0] ref_q;
	logic [SAW_W-1:0] saw_c;
	logic [REF_W-1:0] saw_lim;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ss_q <= '0;
			ss_div_q <= '0;
		end else if (i_ce) begin
			if (!running) begin
				ss_q <= '0;
				ss_div_q <= '0;
			end else if (ss_div_q == DIV_W'(SS_STEP - 1)) begin
				ss_div_q <= '0;
				if (ss_q != FLAT) begin
					ss_q <= ss_q + REF_W'(1);
				end
			end else begin
				ss_div_q <= ss_div_q + DIV_W'(1);
			end
		end
	end

	always_comb begin
		saw_c = SAW_W'(VALLEY)
			+ ((SAW_W'(cnt_q) * SAW_W'(3)) >> 2);
		if (saw_c > SAW_W'(FLAT)) begin
			saw_lim = FLAT;
		end else begin
			saw_lim = saw_c[REF_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ref_q <= '0;
		end else if (i_ce) begin
			ref_q <= (ss_q < saw_lim) ? ss_q : saw_lim;
		end
	end

	////////////////////////////////////////////////////////////////////
	// gate drive
	logic gate_q;
	logic gate_en;

	assign gate_en = running && !otp1_hit;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			gate_q <= 1'b0;
		end else if (i_ce) begin
			if (!gate_en) begin
				gate_q <= 1'b0;
			end else if (cyc_end) begin
				gate_q <= (mode_q != MODE_BURST);
			end else if (gate_q && cs_trip && cnt_q >= PER_W'(TURN_ON_BLANKING)) begin
				gate_q <= 1'b0;
			end else if (cnt_q >= max_on) begin
				gate_q <= 1'b0;
			end
		end
	end

	assign o_gate = gate_q;
	assign o_ilim_ref = ref_q;
	assign o_mode = mode_q;
	assign o_switching = running;
	assign o_auto_fault = (st_q == ST_AUTO);
	assign o_latch_fault = (st_q == ST_LATCH);
	assign o_otp_hold = otp1_hit;

	////////////////////////////////////////////////////////////////////
	// checks
	AST_GATE_IDLE: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && !running |=> !gate_q)
		else $error("gate active outside run state");
	AST_START: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && st_q == ST_OFF && vdd_on && vdd_above_off && !latch_trig
		|=> st_q == ST_RUN)
		else $error("no start at turn-on level");
	AST_NOM_PER: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && running && cyc_end && mode_q == MODE_NOM
		|=> per_q >= PER_W'(P_HMIN) && per_q <= PER_W'(P_HMAX))
		else $error("nominal period outside hopping band");
	AST_REDUCE_PER: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && running && cyc_end && mode_q == MODE_REDUCE
		|=> per_q >= PER_W'(P_NOM) && per_q <= PER_W'(P_GRN))
		else $error("reduced period out of range");
	AST_GREEN_PER: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && running && cyc_end && mode_q == MODE_GREEN
		|=> per_q == PER_W'(P_GRN))
		else $error("green period not at minimum frequency");
	AST_BURST: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && cyc_end && mode_q == MODE_BURST |=> !gate_q)
		else $error("gate started in burst stop");
	AST_AUTO_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && st_q == ST_AUTO && vdd_above_off && !latch_trig
		|=> st_q == ST_AUTO)
		else $error("auto-restart fault left early");
	AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
		st_q == ST_LATCH && vdd_above_4v |=> st_q == ST_LATCH)
		else $error("latched fault cleared above 4V");
	AST_CS_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && gate_q && cs_trip && !cyc_end && cnt_q >= PER_W'(TURN_ON_BLANKING)
		|=> !gate_q)
		else $error("current trip did not end pulse");
	AST_BLANK: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && gate_q && gate_en && !cyc_end && cnt_q < PER_W'(TURN_ON_BLANKING)
		&& cnt_q < max_on |=> gate_q)
		else $error("pulse ended inside blanking window");
	AST_SAW_START: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && running && cnt_q == '0 && ss_q >= VALLEY
		|=> ref_q == VALLEY)
		else $error("sawtooth not at valley at cycle start");
	AST_SS_RESET: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && !running |=> ss_q == '0 && ref_q <= $past(saw_lim))
		else $error("soft-start not restarted");
	AST_OLP_TRIP: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && running && olp_hit && !latch_trig |=> st_q == ST_AUTO)
		else $error("open-loop fault not taken");
endmodule : green_mode_flyback_pwm_core
`default_nettype wire

// ==== verif/switch_sense_model.sv ====
// behavioural power switch and current-sense comparator
`timescale 1ns/1ns
`default_nettype none
module switch_sense_model (
	input wire logic i_clk,
	input wire logic i_gate,
	input wire logic [9:0] i_ref,
	input wire logic [9:0] i_slope,
	output logic o_trip
);
	logic [11:0] cur_q;
	////////////////////////////////////////////////////////////////////
	// drain current ramps only while the switch conducts
	always_ff @(posedge i_clk) begin
		if (!i_gate) begin
			cur_q <= 12'h000;
		end else if (cur_q < 12'hC00) begin
			cur_q <= cur_q + {2'h0, i_slope};
		end
	end
	assign o_trip = i_gate && (cur_q >= {2'h0, i_ref});
endmodule : switch_sense_model
`default_nettype wire

// ==== verif/green_mode_flyback_pwm_core_bench.sv ====
// self-checking bench for the flyback pwm core
`timescale 1ns/1ns
`default_nettype none
module green_mode_flyback_pwm_core_bench;
	import pwm_core_pkg::*;
	logic clk, srst, ce, vdd_on, v_off, v_4v, fb_n, fb_g, fb_z;
	logic [11:0] fb_mv;
	logic [5:0] flt;
	logic [9:0] slope, ilim;
	logic [1:0] mode;
	logic gate, trip, sw, afl, lfl, hold;
	int err_total = 0;
	int checked = 0;
	int p, w, lo, hi, r0, e, n;
	int lo_tab[3] = '{2190, 2150, 2110};
	////////////////////////////////////////////////////////////////////
	green_mode_flyback_pwm_core #(.OLP_CYC(200), .OCP_CYC(200),
		.OTP1_CYC(200), .SS_CYC(1000), .HOP_CYC(800)) dut_u (
		.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_vdd_on(vdd_on),
		.i_vdd_above_off(v_off), .i_vdd_above_4v(v_4v),
		.i_vdd_ovp(flt[3]), .i_fb_above_olp(flt[0]),
		.i_fb_above_n(fb_n), .i_fb_above_g(fb_g),
		.i_fb_above_zdc(fb_z), .i_fb_mv(fb_mv), .i_cs_trip(trip),
		.i_cs_ocp(flt[1]), .i_cs_short(flt[2]),
		.i_rt_below_1v0(flt[4]), .i_rt_below_0v7(flt[5]),
		.o_gate(gate), .o_ilim_ref(ilim), .o_mode(mode),
		.o_switching(sw), .o_auto_fault(afl), .o_latch_fault(lfl),
		.o_otp_hold(hold));
	switch_sense_model sense_u (.i_clk(clk), .i_gate(gate),
		.i_ref(ilim), .i_slope(slope), .o_trip(trip));
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task wrap_up;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask : step
	// cycles until the next rising gate edge
	task rise(output int k);
		k = 0;
		while (gate !== 1'b0 && k < 3000) begin
			step(1);
			k++;
		end
		while (gate !== 1'b1 && k < 3000) begin
			step(1);
			k++;
		end
		if (k >= 3000) begin
			check("gate_edge", 0, 1);
		end
	endtask : rise
	task per(output int k);
		int d;
		rise(d);
		rise(k);
	endtask : per
	task width(output int k);
		int d;
		rise(d);
		k = 0;
		while (gate === 1'b1 && k < 3000) begin
			step(1);
			k++;
		end
	endtask : width
	task power_up;
		v_4v = 1'b1;
		v_off = 1'b1;
		vdd_on = 1'b1;
		step(5);
		check("restart", sw, 1);
	endtask : power_up
	task quiet_gate(input int k);
		n = 0;
		repeat (k) begin
			step(1);
			if (gate !== 1'b0) n++;
		end
	endtask : quiet_gate
	////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		{vdd_on, v_off, v_4v} = 3'h0;
		{fb_n, fb_g, fb_z} = 3'h7;
		fb_mv = 12'h898;
		flt = 6'h00;
		slope = 10'h00A;
		repeat (6) @(posedge clk);
		#10;
		srst = 1'b0;
		check("rst", {gate, ilim, mode, sw, afl, lfl, hold}, 0);
		v_4v = 1'b1;
		v_off = 1'b1;
		step(20);
		check("gate_pre", gate, 0);
		vdd_on = 1'b1;
		step(2);
		check("sw_early", sw, 0);
		step(1);
		check("sw_on", sw, 1);
		step(50);
		check("ss_ref", ilim < 10'd440, 1);
		step(1200);
		check("mode_nom", mode, 2'h0);
		lo = 999;
		hi = 0;
		repeat (12) begin
			per(p);
			lo = (p < lo) ? p : lo;
			hi = (p > hi) ? p : hi;
		end
		check("nom_lo", lo >= 143, 1);
		check("nom_hi", hi <= 165, 1);
		check("hop_span", hi - lo >= 15, 1);
		rise(p);
		step(2);
		r0 = ilim;
		step(40);
		check("saw_low", r0 >= 440 && r0 < 460, 1);
		check("saw_up", ilim > r0, 1);
		slope = 10'h3FF;
		width(w);
		check("blank_w", w >= 5 && w <= 6, 1);
		slope = 10'h00A;
		width(w);
		check("limit_w", w >= 40 && w < 100, 1);
		fb_n = 1'b0;
		foreach (lo_tab[i]) begin
			fb_mv = lo_tab[i];
			step(800);
			check("mode_red", mode, 2'h1);
			per(p);
			e = 153 + ((2200 - lo_tab[i]) * 291) / 100;
			check("red_per", p >= e - 2 && p <= e + 2, 1);
		end
		fb_g = 1'b0;
		step(1000);
		check("mode_grn", mode, 2'h2);
		per(p);
		check("grn_per", p >= 442 && p <= 446, 1);
		fb_z = 1'b0;
		step(500);
		check("mode_bst", mode, 2'h3);
		quiet_gate(1500);
		check("bst_quiet", n, 0);
		fb_z = 1'b1;
		rise(p);
		check("bst_resume", p <= 600, 1);
		{fb_n, fb_g} = 2'h3;
		fb_mv = 12'h898;
		step(1000);
		for (int k = 0; k < 3; k++) begin
			if (k < 2) begin
				flt[k] = 1'b1;
				step(150);
				flt[k] = 1'b0;
				step(5);
				check("deb_restart", afl, 0);
			end
			flt[k] = 1'b1;
			step(k < 2 ? 230 : 10);
			check("auto_set", afl, 1);
			check("auto_gate", gate, 0);
			flt[k] = 1'b0;
			step(20);
			check("auto_keep", {afl, sw}, 2'h2);
			vdd_on = 1'b0;
			v_off = 1'b0;
			step(5);
			check("auto_clr", afl, 0);
			v_off = 1'b1;
			step(10);
			check("wait_on", sw, 0);
			power_up();
		end
		flt[3] = 1'b1;
		step(250);
		flt[3] = 1'b0;
		step(5);
		check("ovp_short", lfl, 0);
		for (int k = 3; k < 6; k += 2) begin
			flt[k] = 1'b1;
			step(k == 3 ? 320 : 1100);
			check("latch_set", {lfl, gate}, 2'h2);
			flt[k] = 1'b0;
			vdd_on = 1'b0;
			v_off = 1'b0;
			step(10);
			check("latch_keep", lfl, 1);
			v_4v = 1'b0;
			step(5);
			check("latch_clr", lfl, 0);
			power_up();
		end
		step(300);
		flt[4] = 1'b1;
		step(230);
		check("otp_hold", hold, 1);
		quiet_gate(500);
		check("otp_quiet", n, 0);
		flt[4] = 1'b0;
		step(10);
		check("otp_free", {hold, lfl}, 2'h0);
		rise(p);
		check("otp_resume", p <= 200, 1);
		wrap_up();
	end
endmodule : green_mode_flyback_pwm_core_bench
`default_nettype wire
